// ==== core/bus_state_track.sv ====
// receiver and transmitter bus state tracking with change detection
`timescale 1ns/1ps
module bus_state_track
  import can_irq_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // error counters from the protocol engine
  input  wire logic [7:0] rx_err_count,
  input  wire logic [8:0] tx_err_count,
  // sensitivity and blocking
  input  wire logic [1:0] rx_state_sensitivity,
  input  wire logic [1:0] tx_state_sensitivity,
  input  wire logic       flag_pending,
  // reported states and flag set request
  output logic      [1:0] rx_bus_state,
  output logic      [1:0] tx_bus_state,
  output logic            change_event
);
  logic [1:0] next_rx;
  logic [1:0] next_tx;
  logic       moved;

  // 00 none, 01 bus-off edge, 10 err or bus-off edge, 11 any change
  function automatic logic sensitive(input logic [1:0] code,
                                     input logic [1:0] prev,
                                     input logic [1:0] cur);
    logic hit;
    hit = 1'b0;
    if (prev != cur) begin
      unique case (code)
        2'h0: hit = 1'b0;
        2'h1: hit = (prev == ST_OFF) || (cur == ST_OFF);
        2'h2: hit = (prev >= ST_ERR) || (cur >= ST_ERR);
        2'h3: hit = 1'b1;
      endcase
    end
    return hit;
  endfunction : sensitive

  function automatic logic [1:0] level(input logic [8:0] cnt);
    logic [1:0] s;
    s = ST_OK;
    if (cnt > CNT_OFF) s = ST_OFF;
    else if (cnt > CNT_ERR) s = ST_ERR;
    else if (cnt > CNT_WARN) s = ST_WARN;
    return s;
  endfunction : level

  always_comb begin
    next_tx = level(tx_err_count);
    if (tx_err_count > CNT_OFF) next_rx = ST_OFF;
    else if (rx_bus_state == ST_OFF) next_rx = ST_OK;
    else begin
      next_rx = level({1'b0, rx_err_count});
      if (next_rx == ST_OFF) next_rx = ST_ERR;
    end
  end

  // states freeze while a status change is pending
  assign moved = !flag_pending &&
                 (next_rx != rx_bus_state || next_tx != tx_bus_state);
  assign change_event = moved &&
    (sensitive(rx_state_sensitivity, rx_bus_state, next_rx) ||
     sensitive(tx_state_sensitivity, tx_bus_state, next_tx));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_bus_state <= ST_OK;
      tx_bus_state <= ST_OK;
    end else if (moved) begin
      rx_bus_state <= next_rx;
      tx_bus_state <= next_tx;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_state_frozen: assert property (
    flag_pending |=> $stable(rx_bus_state) && $stable(tx_bus_state))
    else $error("bus state moved while status change pending");
endmodule : bus_state_track

// ==== core/can_irq_enable_tx_flags.sv ====
// receive irq enables, transmit empty flags and abort bookkeeping
`timescale 1ns/1ps
module can_irq_enable_tx_flags
  import can_irq_pkg::*;
#(
  parameter int NBUF = 3
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // axi4-lite write address and data
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // protocol engine events, same clock
  input  wire logic [7:0]        rx_err_count,
  input  wire logic [8:0]        tx_err_count,
  input  wire logic              wake_event,
  input  wire logic              overrun_event,
  input  wire logic              rx_msg_event,
  input  wire logic [NBUF-1:0]   tx_done,
  input  wire logic [NBUF-1:0]   abort_done,
  // to the protocol engine
  output logic [NBUF-1:0]        tx_start_req,
  output logic [NBUF-1:0]        tx_buf_blocked,
  output logic [NBUF-1:0]        abort_request,
  output logic                   init_acknowledge,
  // interrupt requests
  output logic                   wake_irq,
  output logic                   error_irq,
  output logic                   rx_irq,
  output logic                   tx_irq
);
  logic [7:0]        ctrl;
  logic [7:0]        rx_irq_enable;
  logic [NBUF-1:0]   tx_empty_flags;
  logic [NBUF-1:0]   tx_irq_enable;
  logic [NBUF-1:0]   abort_ack;
  logic              wake_flag;
  logic              status_change_flag;
  logic              overrun_flag;
  logic              rx_full_flag;
  logic [1:0]        rx_bus_state;
  logic [1:0]        tx_bus_state;
  logic              change_event;
  logic              aw_held;
  logic              w_held;
  logic [AXI_AW-1:0] aw_addr;
  logic [7:0]        w_byte;
  logic              w_lane0;
  logic              wr_fire;
  logic              init_mode;
  logic              listen;
  logic [NBUF-1:0]   tx_clear;
  logic [NBUF-1:0]   tx_set;
  logic [NBUF-1:0]   abort_hit;
  logic [7:0]        rd_word;
  logic              rd_hit;

  assign init_mode = ctrl[BIT_INIT_REQ] && init_acknowledge;
  assign listen    = ctrl[BIT_LISTEN];

  // write side: address and data may arrive in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_held  <= 1'b0;
      w_byte  <= '0;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      w_byte  <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    return a == ADDR_CTRL || a == ADDR_RX_FLAGS ||
           a == ADDR_RX_IRQ_EN || a == ADDR_TX_FLAG ||
           a == ADDR_TX_IRQ_EN || a == ADDR_ABORT_REQ ||
           a == ADDR_ABORT_ACK;
  endfunction : is_mapped

  function automatic logic wr_to(input logic [AXI_AW-1:0] a,
                                 input logic [AXI_AW-1:0] target,
                                 input logic fire,
                                 input logic lane);
    return fire && lane && (a == target);
  endfunction : wr_to

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control: init request, listen mode, wake function; ack follows request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RST;
    end else if (wr_to(aw_addr, ADDR_CTRL, wr_fire, w_lane0)) begin
      ctrl <= w_byte;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      init_acknowledge <= 1'b0;
    end else begin
      init_acknowledge <= ctrl[BIT_INIT_REQ];
    end
  end

  // receive irq enables; the sensitivity fields keep their value in init
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_irq_enable <= RX_IRQ_EN_RST;
    end else if (init_mode) begin
      rx_irq_enable[BIT_WAKE] <= RX_IRQ_EN_RST[BIT_WAKE];
      rx_irq_enable[BIT_SCF]  <= RX_IRQ_EN_RST[BIT_SCF];
      rx_irq_enable[BIT_OVR]  <= RX_IRQ_EN_RST[BIT_OVR];
      rx_irq_enable[BIT_RXF]  <= RX_IRQ_EN_RST[BIT_RXF];
    end else if (wr_to(aw_addr, ADDR_RX_IRQ_EN, wr_fire, w_lane0)) begin
      rx_irq_enable <= w_byte;
    end
  end

  bus_state_track u_track (
    .clk                  (clk),
    .rst_b                (rst_b),
    .rx_err_count         (rx_err_count),
    .tx_err_count         (tx_err_count),
    .rx_state_sensitivity (rx_irq_enable[BIT_RS+:2]),
    .tx_state_sensitivity (rx_irq_enable[BIT_TS+:2]),
    .flag_pending         (status_change_flag),
    .rx_bus_state         (rx_bus_state),
    .tx_bus_state         (tx_bus_state),
    .change_event         (change_event)
  );

  // receive flags: write 1 clears, a new event in the same cycle wins
  function automatic logic w1c(input logic cur, input logic set,
                               input logic clr);
    return set || (cur && !clr);
  endfunction : w1c

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_flag          <= 1'b0;
      status_change_flag <= 1'b0;
      overrun_flag       <= 1'b0;
      rx_full_flag       <= 1'b0;
    end else begin
      wake_flag <= w1c(wake_flag,
        wake_event && ctrl[BIT_WAKE_FN],
        wr_to(aw_addr, ADDR_RX_FLAGS, wr_fire, w_lane0) && w_byte[BIT_WAKE]);
      status_change_flag <= w1c(status_change_flag, change_event,
        wr_to(aw_addr, ADDR_RX_FLAGS, wr_fire, w_lane0) && w_byte[BIT_SCF]);
      overrun_flag <= w1c(overrun_flag, overrun_event,
        wr_to(aw_addr, ADDR_RX_FLAGS, wr_fire, w_lane0) && w_byte[BIT_OVR]);
      rx_full_flag <= w1c(rx_full_flag, rx_msg_event,
        wr_to(aw_addr, ADDR_RX_FLAGS, wr_fire, w_lane0) && w_byte[BIT_RXF]);
    end
  end

  assign wake_irq  = wake_flag && rx_irq_enable[BIT_WAKE];
  assign error_irq = (status_change_flag && rx_irq_enable[BIT_SCF]) ||
                     (overrun_flag && rx_irq_enable[BIT_OVR]);
  assign rx_irq    = rx_full_flag && rx_irq_enable[BIT_RXF];

  // transmit flags: engine sets win over a clearing write
  assign abort_hit = abort_done & abort_request & ~tx_empty_flags;
  assign tx_set    = (tx_done & ~tx_empty_flags) | abort_hit;
  assign tx_clear  = (wr_to(aw_addr, ADDR_TX_FLAG, wr_fire, w_lane0)
                      && !listen) ? w_byte[NBUF-1:0] : '0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_empty_flags <= TX_FLAG_RST;
    end else if (init_mode) begin
      tx_empty_flags <= TX_FLAG_RST;
    end else begin
      tx_empty_flags <= tx_set | (tx_empty_flags & ~tx_clear);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_irq_enable <= '0;
    end else if (init_mode) begin
      tx_irq_enable <= '0;
    end else if (wr_to(aw_addr, ADDR_TX_IRQ_EN, wr_fire, w_lane0)) begin
      tx_irq_enable <= w_byte[NBUF-1:0];
    end
  end

  // software may only raise abort requests, for scheduled buffers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      abort_request <= '0;
    end else if (init_mode) begin
      abort_request <= '0;
    end else if (wr_to(aw_addr, ADDR_ABORT_REQ, wr_fire, w_lane0)) begin
      abort_request <= (abort_request | (w_byte[NBUF-1:0] & ~tx_empty_flags))
                       & ~tx_set;
    end else begin
      abort_request <= abort_request & ~tx_set;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      abort_ack <= '0;
    end else if (init_mode) begin
      abort_ack <= '0;
    end else begin
      abort_ack <= abort_hit |
                   (abort_ack & ~(tx_clear & tx_empty_flags & ~tx_set));
    end
  end

  assign tx_irq         = |(tx_empty_flags & tx_irq_enable);
  assign tx_start_req   = (listen || init_mode) ? '0 :
                          ~tx_empty_flags;
  assign tx_buf_blocked = ~tx_empty_flags;

  // read side
  always_comb begin
    rd_word = 8'h00;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL: begin
        rd_word               = ctrl;
        rd_word[BIT_INIT_ACK] = init_acknowledge;
      end
      ADDR_RX_FLAGS: rd_word = {wake_flag, status_change_flag,
                                rx_bus_state, tx_bus_state,
                                overrun_flag, rx_full_flag};
      ADDR_RX_IRQ_EN: rd_word = rx_irq_enable;
      ADDR_TX_FLAG:   rd_word[NBUF-1:0] = tx_empty_flags;
      ADDR_TX_IRQ_EN: rd_word[NBUF-1:0] = tx_irq_enable;
      ADDR_ABORT_REQ: rd_word[NBUF-1:0] = abort_request;
      ADDR_ABORT_ACK: rd_word[NBUF-1:0] = abort_ack;
      default:        rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_word};
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_init_hold: assert property (
    init_mode |=> tx_empty_flags == TX_FLAG_RST &&
                  rx_irq_enable[BIT_WAKE] == 1'b0 && abort_ack == '0)
    else $error("registers not held in reset during init");

  chk_sens_keep: assert property (
    $rose(init_mode) |=> $stable(rx_irq_enable[5:2]))
    else $error("sensitivity fields changed on init entry");

  chk_rie_write: assert property (
    wr_to(aw_addr, ADDR_RX_IRQ_EN, wr_fire, w_lane0) && !init_mode
    |=> rx_irq_enable == $past(w_byte))
    else $error("receive irq enable write lost");

  chk_wake_path: assert property (
    wake_event && ctrl[BIT_WAKE_FN] && rx_irq_enable[BIT_WAKE] && !init_mode
    && !wr_to(aw_addr, ADDR_RX_IRQ_EN, wr_fire, w_lane0) |=> wake_irq)
    else $error("wake event did not raise request");

  chk_ovr_path: assert property (
    overrun_event && rx_irq_enable[BIT_OVR] && !init_mode
    && !wr_to(aw_addr, ADDR_RX_IRQ_EN, wr_fire, w_lane0) |=> error_irq)
    else $error("overrun did not raise error request");

  chk_txe_done: assert property (
    !init_mode && !$past(init_mode) && $past(tx_done != '0)
    |-> (tx_empty_flags & $past(tx_done)) == $past(tx_done))
    else $error("transmitted buffer not flagged empty");

  chk_listen_hold: assert property (
    listen && !init_mode |=> (~tx_empty_flags & $past(tx_empty_flags)) == '0)
    else $error("empty flag cleared in listen mode");

  chk_abort_drop: assert property (
    !init_mode |=> (tx_empty_flags & ~$past(tx_empty_flags)
                    & abort_request) == '0)
    else $error("abort request survived empty flag set");

  chk_ack_clear: assert property (
    !init_mode |=> (~tx_empty_flags & $past(tx_empty_flags)
                    & abort_ack) == '0)
    else $error("abort ack survived flag clear");

  chk_tx_irq: assert property (
    !init_mode && tx_done[0] && tx_irq_enable[0]
    && !wr_to(aw_addr, ADDR_TX_IRQ_EN, wr_fire, w_lane0) |=> tx_irq)
    else $error("transmit request missing after empty");
endmodule : can_irq_enable_tx_flags

// ==== core/can_irq_pkg.sv ====
// constants for the receive irq enable and transmit flag block
package can_irq_pkg;
  localparam int AXI_AW = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL      = 8'h00;
  localparam logic [7:0] IDX_RX_FLAGS  = 8'h04;
  localparam logic [7:0] IDX_RX_IRQ_EN = 8'h05;
  localparam logic [7:0] IDX_TX_FLAG   = 8'h06;
  localparam logic [7:0] IDX_TX_IRQ_EN = 8'h07;
  localparam logic [7:0] IDX_ABORT_REQ = 8'h08;
  localparam logic [7:0] IDX_ABORT_ACK = 8'h09;
  localparam logic [7:0] ADDR_CTRL      = IDX_CTRL << 2;
  localparam logic [7:0] ADDR_RX_FLAGS  = IDX_RX_FLAGS << 2;
  localparam logic [7:0] ADDR_RX_IRQ_EN = IDX_RX_IRQ_EN << 2;
  localparam logic [7:0] ADDR_TX_FLAG   = IDX_TX_FLAG << 2;
  localparam logic [7:0] ADDR_TX_IRQ_EN = IDX_TX_IRQ_EN << 2;
  localparam logic [7:0] ADDR_ABORT_REQ = IDX_ABORT_REQ << 2;
  localparam logic [7:0] ADDR_ABORT_ACK = IDX_ABORT_ACK << 2;
  // bit positions in the flag and enable registers
  localparam int BIT_WAKE = 7;
  localparam int BIT_SCF  = 6;
  localparam int BIT_RS   = 4;
  localparam int BIT_TS   = 2;
  localparam int BIT_OVR  = 1;
  localparam int BIT_RXF  = 0;
  // control register bits
  localparam int BIT_INIT_REQ = 0;
  localparam int BIT_LISTEN   = 1;
  localparam int BIT_WAKE_FN  = 2;
  localparam int BIT_INIT_ACK = 3;
  // values after reset
  localparam logic [7:0] RX_IRQ_EN_RST = 8'h00;
  localparam logic [7:0] CTRL_RST      = 8'h01;
  localparam logic [2:0] TX_FLAG_RST   = 3'h7;
  // bus state codes and error counter thresholds
  localparam logic [1:0] ST_OK   = 2'h0;
  localparam logic [1:0] ST_WARN = 2'h1;
  localparam logic [1:0] ST_ERR  = 2'h2;
  localparam logic [1:0] ST_OFF  = 2'h3;
  localparam logic [8:0] CNT_WARN = 9'h060;
  localparam logic [8:0] CNT_ERR  = 9'h07F;
  localparam logic [8:0] CNT_OFF  = 9'h0FF;
endpackage : can_irq_pkg

// ==== verif/can_irq_enable_tx_flags_test.sv ====
// bench for receive irq enables and transmit empty flags
`timescale 1ns/1ps
module can_irq_enable_tx_flags_test
  import can_irq_pkg::*;
;
  logic        clk = 0, rst_b = 0, go_tx = 0, go_abort = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, rx_err_count = 0, d;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, init_acknowledge;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [8:0]  tx_err_count = 0;
  logic        wake_event = 0, overrun_event = 0, rx_msg_event = 0;
  logic [2:0]  tx_done, abort_done, tx_start_req, tx_buf_blocked;
  logic [2:0]  abort_request;
  logic        wake_irq, error_irq, rx_irq, tx_irq;
  int          fail_count = 0, checks = 0;

  always #2.5 clk = ~clk;
  can_irq_enable_tx_flags can_irq_enable_tx_flags_inst (
    .clk              (clk),
    .rst_b            (rst_b),
    .s_axi_awaddr     (s_axi_awaddr),
    .s_axi_awvalid    (s_axi_awvalid),
    .s_axi_awready    (s_axi_awready),
    .s_axi_wdata      (s_axi_wdata),
    .s_axi_wstrb      (s_axi_wstrb),
    .s_axi_wvalid     (s_axi_wvalid),
    .s_axi_wready     (s_axi_wready),
    .s_axi_bresp      (s_axi_bresp),
    .s_axi_bvalid     (s_axi_bvalid),
    .s_axi_bready     (s_axi_bready),
    .s_axi_araddr     (s_axi_araddr),
    .s_axi_arvalid    (s_axi_arvalid),
    .s_axi_arready    (s_axi_arready),
    .s_axi_rdata      (s_axi_rdata),
    .s_axi_rresp      (s_axi_rresp),
    .s_axi_rvalid     (s_axi_rvalid),
    .s_axi_rready     (s_axi_rready),
    .rx_err_count     (rx_err_count),
    .tx_err_count     (tx_err_count),
    .wake_event       (wake_event),
    .overrun_event    (overrun_event),
    .rx_msg_event     (rx_msg_event),
    .tx_done          (tx_done),
    .abort_done       (abort_done),
    .tx_start_req     (tx_start_req),
    .tx_buf_blocked   (tx_buf_blocked),
    .abort_request    (abort_request),
    .init_acknowledge (init_acknowledge),
    .wake_irq         (wake_irq),
    .error_irq        (error_irq),
    .rx_irq           (rx_irq),
    .tx_irq           (tx_irq)
  );
  engine_model engine_model_inst (
    .clk           (clk),
    .go_tx         (go_tx),
    .go_abort      (go_abort),
    .tx_start_req  (tx_start_req),
    .abort_request (abort_request),
    .tx_done       (tx_done),
    .abort_done    (abort_done)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ready is sampled at the falling edge so the rising edge never races it
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata[7:0];
      resp = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(d, e);
  endtask : rc

  // bits: wake, overrun, rx message, transmit, abort
  task automatic pulse(input logic [4:0] e);
    {wake_event, overrun_event, rx_msg_event, go_tx, go_abort} <= e;
    @(posedge clk);
    {wake_event, overrun_event, rx_msg_event, go_tx, go_abort} <= 5'h00;
    @(posedge clk);
  endtask : pulse

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    #50000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rc(ADDR_TX_FLAG, 8'h07);
    rc(ADDR_CTRL, 8'h09);
    chk(init_acknowledge, 1'b1);
    wr(ADDR_RX_IRQ_EN, 8'hFF);
    rc(ADDR_RX_IRQ_EN, 8'h00);
    rd(8'hFC);
    chk(resp, RESP_SLVERR);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_RX_IRQ_EN, 8'hFF);
    chk(resp, RESP_OKAY);
    rc(ADDR_RX_IRQ_EN, 8'hFF);
    wr(ADDR_TX_FLAG, 8'h01);
    rc(ADDR_TX_FLAG, 8'h06);
    wr(ADDR_CTRL, 8'h01);
    rc(ADDR_RX_IRQ_EN, 8'h3C);
    rc(ADDR_TX_FLAG, 8'h07);
    $display("test init mode finished");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_TX_FLAG, 8'h00);
    rc(ADDR_TX_FLAG, 8'h07);
    wr(ADDR_TX_IRQ_EN, 8'h01);
    wr(ADDR_TX_FLAG, 8'h01);
    rc(ADDR_TX_FLAG, 8'h06);
    chk(tx_buf_blocked, 3'h1);
    chk(tx_irq, 1'b0);
    pulse(5'h02);
    rc(ADDR_TX_FLAG, 8'h07);
    chk(tx_irq, 1'b1);
    wr(ADDR_TX_FLAG, 8'h02);
    wr(ADDR_ABORT_REQ, 8'h02);
    chk(abort_request, 3'h2);
    pulse(5'h01);
    rc(ADDR_TX_FLAG, 8'h07);
    chk(abort_request, 3'h0);
    rc(ADDR_ABORT_ACK, 8'h02);
    wr(ADDR_TX_FLAG, 8'h02);
    rc(ADDR_ABORT_ACK, 8'h00);
    $display("test transmit flags finished");
    wr(ADDR_CTRL, 8'h02);
    chk(tx_start_req, 3'h0);
    wr(ADDR_TX_FLAG, 8'h04);
    rc(ADDR_TX_FLAG, 8'h05);
    wr(ADDR_CTRL, 8'h04);
    chk(tx_start_req, 3'h2);
    pulse(5'h02);
    rc(ADDR_TX_FLAG, 8'h07);
    $display("test listen mode finished");
    wr(ADDR_RX_IRQ_EN, 8'h83);
    pulse(5'h1C);
    chk({wake_irq, error_irq, rx_irq}, 3'h7);
    wr(ADDR_RX_IRQ_EN, 8'h00);
    chk({wake_irq, error_irq, rx_irq}, 3'h0);
    wr(ADDR_RX_FLAGS, 8'h83);
    wr(ADDR_RX_IRQ_EN, 8'h44);
    tx_err_count <= 9'h100;
    repeat (3) @(posedge clk);
    chk(error_irq, 1'b1);
    rd(ADDR_RX_FLAGS);
    chk(d & 8'hCC, 8'h4C);
    tx_err_count <= 9'h000;
    repeat (3) @(posedge clk);
    rd(ADDR_RX_FLAGS);
    chk(d & 8'h4C, 8'h4C);
    // receiver bus-off edges only, then any receiver change; leaving bus-off must flag again
    wr(ADDR_RX_IRQ_EN, 8'h50);
    wr(ADDR_RX_FLAGS, 8'h40);
    rd(ADDR_RX_FLAGS);
    chk(d & 8'h7C, 8'h40);
    rx_err_count <= 8'h61;
    wr(ADDR_RX_FLAGS, 8'h40);
    rd(ADDR_RX_FLAGS);
    chk(d & 8'h7C, 8'h10);
    wr(ADDR_RX_IRQ_EN, 8'h70);
    rx_err_count <= 8'h00;
    repeat (3) @(posedge clk);
    chk(error_irq, 1'b1);
    rd(ADDR_RX_FLAGS);
    chk(d & 8'h7C, 8'h40);
    $display("test interrupt enables finished");
    tally_and_finish();
  end
endmodule : can_irq_enable_tx_flags_test

// ==== verif/engine_model.sv ====
// far side stand-in: finishes or aborts offered buffers on command
`timescale 1ns/1ps
module engine_model (
  // clock
  input  wire logic       clk,
  // commands from the bench
  input  wire logic       go_tx,
  input  wire logic       go_abort,
  // design side
  input  wire logic [2:0] tx_start_req,
  input  wire logic [2:0] abort_request,
  output logic      [2:0] tx_done = 3'h0,
  output logic      [2:0] abort_done = 3'h0
);
  // only buffers the design offers can complete, so a stuck request shows
  always @(posedge clk) begin
    tx_done    <= go_tx ? tx_start_req : 3'h0;
    abort_done <= go_abort ? abort_request : 3'h0;
  end
endmodule : engine_model
